// ---- aecs_top.sv ----
// Status, error and setup logic of a two-port absolute encoder counter
// Function
// - Port 1 match bits 0-7 high while comparing and count lies within ranges 1-8
// - Port 2 match bits 0-7 high while comparing and count lies within ranges 1-8
// - Bit 8 of each port's status word high while comparing
// - Compensation request bits 1 and 2 trigger port 1 and 2 compensation
// - System status bit 15 high whenever the board has an error
// - Error code bits 8-15: 00 none, 01/02 hardware, 03 setup
// - One 16-bit BCD origin offset word per port
// - Compensate only on request rising while in program mode
// - Setup word: resolution bits 0-7, mode bits 8-15, latched at start for count mask and error check
// - 8-digit BCD present count in two words, refreshed each scan cycle
// - Request bit cleared automatically after storing the offset
// - Present count reads zero right after compensation
//
// The implementer's own choices: the register offsets and the plain strobed port.
module aecs_top #(
  parameter int SCAN_CYCLES = aecs_pkg::SCAN_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Encoder gray inputs
  input wire logic [11:0] enc1_gray_i,
  input wire logic [11:0] enc2_gray_i,
  // Comparison ranges, eight per port
  input wire aecs_pkg::aecs_limit_s [7:0] range1_i,
  input wire aecs_pkg::aecs_limit_s [7:0] range2_i,
  // Board hardware fault code, 00 when healthy
  input wire logic [7:0] hw_fault_i,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [11:0] gray2bin(input logic [11:0] g);
    logic [11:0] b;
    b = '0;
    b[11] = g[11];
    for (int i = 10; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [11:0] mask_res(input logic [11:0] v, input logic [7:0] res);
    logic [11:0] r;
    r = v;
    if (res == aecs_pkg::RES_8)
    begin
      r = {4'h0, v[7:0]};
    end
    else if (res == aecs_pkg::RES_10)
    begin
      r = {2'h0, v[9:0]};
    end
    return r;
  endfunction

  function automatic logic [15:0] bin2bcd(input logic [11:0] v);
    logic [27:0] s;
    s = {16'h0000, v};
    for (int i = 0; i < 12; i++)
    begin
      for (int d = 0; d < 4; d++)
      begin
        if (s[12+4*d +: 4] > 4'h4)
        begin
          s[12+4*d +: 4] = s[12+4*d +: 4] + 4'h3;
        end
      end
      s = {s[26:0], 1'b0};
    end
    return s[27:12];
  endfunction

  function automatic logic [11:0] bcd2bin(input logic [15:0] b);
    logic [15:0] r;
    r = 16'(b[15:12]) * 16'd1000 + 16'(b[11:8]) * 16'd100 + 16'(b[7:4]) * 16'd10 + 16'(b[3:0]);
    return r[11:0];
  endfunction

  function automatic logic [7:0] match8(input logic [11:0] v, input aecs_pkg::aecs_limit_s [7:0] rg);
    logic [7:0] m;
    m = '0;
    for (int k = 0; k < 8; k++)
    begin
      m[k] = ({4'h0, rg[k].lower} <= v) && (v <= {4'h0, rg[k].upper});
    end
    return m;
  endfunction

  function automatic logic setup_bad(input aecs_pkg::aecs_setup_s s);
    return (s.res > aecs_pkg::RES_12) || (s.mode > aecs_pkg::MODE_DEG);
  endfunction

  // ----------------------------------------
  // Scan cycle divider
  // ----------------------------------------
  logic [$clog2(SCAN_CYCLES+1)-1:0] scan_cnt_q;
  logic scan_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      scan_cnt_q <= '0;
      scan_q <= 1'b0;
    end
    else
    begin
      scan_q <= (scan_cnt_q == ($bits(scan_cnt_q))'(SCAN_CYCLES - 1));
      scan_cnt_q <= (scan_cnt_q == ($bits(scan_cnt_q))'(SCAN_CYCLES - 1)) ? '0 : scan_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [15:0] ctrl_q;
  logic [15:0] irq_mask_q;
  aecs_pkg::aecs_setup_s setup1_q, setup2_q, act1_q, act2_q;
  logic [15:0] off1_q, off2_q;
  logic [1:0] req_q;
  logic prog_q;
  logic [1:0] run_q;

  wire wr_req = reg_wr_i && reg_addr_i == aecs_pkg::ADDR_COMP_REQ;

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      ctrl_q <= aecs_pkg::CTRL_RST;
      irq_mask_q <= aecs_pkg::RST_WORD;
      setup1_q <= aecs_pkg::RST_WORD;
      setup2_q <= aecs_pkg::RST_WORD;
    end
    else if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        aecs_pkg::ADDR_CTRL: ctrl_q <= reg_wdata_i;
        aecs_pkg::ADDR_IRQ_MASK: irq_mask_q <= reg_wdata_i;
        aecs_pkg::ADDR_P1_SETUP: setup1_q <= reg_wdata_i;
        aecs_pkg::ADDR_P2_SETUP: setup2_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  assign prog_q = ctrl_q[aecs_pkg::BIT_CTRL_PROG];
  assign run_q = {ctrl_q[aecs_pkg::BIT_CTRL_RUN2], ctrl_q[aecs_pkg::BIT_CTRL_RUN1]} & {2{~prog_q}};

  // Setup latched when operation starts; the count mask and error check wait for the next start, raw1/raw2 masking takes edits at once
  logic prog_d1_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      prog_d1_q <= 1'b1;
      act1_q <= aecs_pkg::RST_WORD;
      act2_q <= aecs_pkg::RST_WORD;
    end
    else
    begin
      prog_d1_q <= prog_q;
      if (prog_d1_q && !prog_q)
      begin
        act1_q <= setup1_q;
        act2_q <= setup2_q;
      end
    end
  end

  // ----------------------------------------
  // Origin compensation
  // ----------------------------------------
  logic [11:0] raw1, raw2;
  assign raw1 = mask_res(gray2bin(enc1_gray_i), setup1_q.res);
  assign raw2 = mask_res(gray2bin(enc2_gray_i), setup2_q.res);

  logic [1:0] req_rise;
  assign req_rise = {reg_wdata_i[aecs_pkg::BIT_COMP_P2], reg_wdata_i[aecs_pkg::BIT_COMP_P1]} & ~req_q & {2{wr_req}};
  logic [1:0] comp_go;
  assign comp_go = req_rise & {2{prog_q}};

  // Request is held for one cycle then dropped; a request outside program mode stays set
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      req_q <= 2'b00;
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        if (req_q[p] && prog_q)
        begin
          req_q[p] <= 1'b0;
        end
        else if (wr_req)
        begin
          req_q[p] <= reg_wdata_i[p+1];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      off1_q <= aecs_pkg::RST_WORD;
      off2_q <= aecs_pkg::RST_WORD;
    end
    else
    begin
      if (comp_go[0])
      begin
        off1_q <= bin2bcd(raw1);
      end
      else if (reg_wr_i && reg_addr_i == aecs_pkg::ADDR_P1_OFFSET)
      begin
        off1_q <= reg_wdata_i;
      end
      if (comp_go[1])
      begin
        off2_q <= bin2bcd(raw2);
      end
      else if (reg_wr_i && reg_addr_i == aecs_pkg::ADDR_P2_OFFSET)
      begin
        off2_q <= reg_wdata_i;
      end
    end
  end

  // ----------------------------------------
  // Present count and comparison
  // ----------------------------------------
  function automatic logic [11:0] adj(input logic [11:0] raw, input logic [15:0] off, input logic [7:0] res);
    return mask_res(raw - bcd2bin(off), res);
  endfunction

  logic [11:0] pos1, pos2;
  // Counting applies the resolution latched at start on top of raw1/raw2, which are masked by the live setup word
  assign pos1 = adj(raw1, off1_q, act1_q.res);
  assign pos2 = adj(raw2, off2_q, act2_q.res);

  aecs_pkg::aecs_count_s cnt1_q, cnt2_q;
  logic [8:0] st1_q, st2_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      cnt1_q <= '0;
      cnt2_q <= '0;
    end
    else
    begin
      if (comp_go[0])
      begin
        cnt1_q <= '0;
      end
      else if (scan_q)
      begin
        cnt1_q <= {16'h0000, bin2bcd(pos1)};
      end
      if (comp_go[1])
      begin
        cnt2_q <= '0;
      end
      else if (scan_q)
      begin
        cnt2_q <= {16'h0000, bin2bcd(pos2)};
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      st1_q <= '0;
      st2_q <= '0;
    end
    else
    begin
      st1_q <= {run_q[0], match8(pos1, range1_i) & {8{run_q[0]}}};
      st2_q <= {run_q[1], match8(pos2, range2_i) & {8{run_q[1]}}};
    end
  end

  // ----------------------------------------
  // Board error
  // ----------------------------------------
  logic [7:0] err_code_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      err_code_q <= aecs_pkg::ERR_NONE;
    end
    else if (hw_fault_i != aecs_pkg::ERR_NONE)
    begin
      err_code_q <= hw_fault_i;
    end
    else if (setup_bad(act1_q) || setup_bad(act2_q))
    begin
      err_code_q <= aecs_pkg::ERR_SETUP;
    end
    else
    begin
      err_code_q <= aecs_pkg::ERR_NONE;
    end
  end

  // ----------------------------------------
  // Interrupt: bit0 compensation done, bit1 error, bits 2/3 port matches
  // ----------------------------------------
  logic [15:0] irq_stat_q;
  logic [15:0] ev;
  assign ev = {12'h000, |st2_q[7:0], |st1_q[7:0], err_code_q != aecs_pkg::ERR_NONE, |comp_go};

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      irq_stat_q <= aecs_pkg::RST_WORD;
      irq_o <= 1'b0;
    end
    else
    begin
      // Set beats the write-one clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~(reg_wr_i && reg_addr_i == aecs_pkg::ADDR_IRQ_STATUS ? reg_wdata_i : 16'h0000)) | ev;
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      reg_rdata_o <= aecs_pkg::RST_WORD;
    end
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        aecs_pkg::ADDR_P1_MATCH: reg_rdata_o <= {7'h00, st1_q};
        aecs_pkg::ADDR_P2_MATCH: reg_rdata_o <= {7'h00, st2_q};
        aecs_pkg::ADDR_COMP_REQ: reg_rdata_o <= {13'h0000, req_q, 1'b0};
        aecs_pkg::ADDR_SYS_ERR: reg_rdata_o <= {err_code_q != aecs_pkg::ERR_NONE, 15'h0000};
        aecs_pkg::ADDR_ERR_CODE: reg_rdata_o <= {err_code_q, 8'h00};
        aecs_pkg::ADDR_P1_OFFSET: reg_rdata_o <= off1_q;
        aecs_pkg::ADDR_P2_OFFSET: reg_rdata_o <= off2_q;
        aecs_pkg::ADDR_P1_SETUP: reg_rdata_o <= setup1_q;
        aecs_pkg::ADDR_P2_SETUP: reg_rdata_o <= setup2_q;
        aecs_pkg::ADDR_P1_COUNT_LO: reg_rdata_o <= cnt1_q.lo;
        aecs_pkg::ADDR_P1_COUNT_HI: reg_rdata_o <= cnt1_q.hi;
        aecs_pkg::ADDR_P2_COUNT_LO: reg_rdata_o <= cnt2_q.lo;
        aecs_pkg::ADDR_P2_COUNT_HI: reg_rdata_o <= cnt2_q.hi;
        aecs_pkg::ADDR_IRQ_STATUS: reg_rdata_o <= irq_stat_q;
        aecs_pkg::ADDR_IRQ_MASK: reg_rdata_o <= irq_mask_q;
        aecs_pkg::ADDR_CTRL: reg_rdata_o <= ctrl_q;
      endcase
    end
    else
    begin
      reg_rdata_o <= aecs_pkg::RST_WORD;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_match1;
    @(posedge clk_sys_i) disable iff (!nrst_i) !run_q[0] |=> st1_q == 9'h000;
  endproperty
  a_match1: assert property (p_match1) else $error("port1 flags set while stopped");

  property p_match2;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      run_q[1] && {4'h0, range2_i[3].lower} <= pos2 && pos2 <= {4'h0, range2_i[3].upper} |=> st2_q[3];
  endproperty
  a_match2: assert property (p_match2) else $error("port2 match flags wrong");

  property p_run;
    @(posedge clk_sys_i) disable iff (!nrst_i) ##1 st1_q[8] == $past(run_q[0]) && st2_q[8] == $past(run_q[1]);
  endproperty
  a_run: assert property (p_run) else $error("comparing flag wrong");

  property p_req;
    @(posedge clk_sys_i) disable iff (!nrst_i) wr_req && !req_q[0] && reg_wdata_i[1] |=> req_q[0];
  endproperty
  a_req: assert property (p_req) else $error("request bit not taken");

  property p_err;
    @(posedge clk_sys_i) disable iff (!nrst_i) hw_fault_i != 8'h00 |=> err_code_q == $past(hw_fault_i);
  endproperty
  a_err: assert property (p_err) else $error("error code not reported");

  property p_comp;
    @(posedge clk_sys_i) disable iff (!nrst_i) comp_go[0] |=> cnt1_q == 32'h0 && bcd2bin(off1_q) == $past(raw1);
  endproperty
  a_comp: assert property (p_comp) else $error("compensation wrong");

  sequence s_req_set;
    wr_req && reg_wdata_i[1] && !req_q[0] && prog_q && prog_d1_q;
  endsequence
  property p_autoclr;
    @(posedge clk_sys_i) disable iff (!nrst_i) s_req_set ##1 prog_q |=> !req_q[0];
  endproperty
  a_autoclr: assert property (p_autoclr) else $error("request not cleared");

  property p_nocomp;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !prog_q && !(reg_wr_i && reg_addr_i == aecs_pkg::ADDR_P1_OFFSET) |=> $stable(off1_q);
  endproperty
  a_nocomp: assert property (p_nocomp) else $error("offset changed outside program mode");
endmodule

// ---- aecs_pkg.sv ----
// Package: register map, field layout and constants of the encoder counter status block
package aecs_pkg;
  // ----------------------------------------
  // Register indices (word addresses)
  // ----------------------------------------
  localparam logic [3:0] ADDR_P1_MATCH = 4'h0;
  localparam logic [3:0] ADDR_P2_MATCH = 4'h1;
  localparam logic [3:0] ADDR_COMP_REQ = 4'h2;
  localparam logic [3:0] ADDR_SYS_ERR = 4'h3;
  localparam logic [3:0] ADDR_ERR_CODE = 4'h4;
  localparam logic [3:0] ADDR_P1_OFFSET = 4'h5;
  localparam logic [3:0] ADDR_P2_OFFSET = 4'h6;
  localparam logic [3:0] ADDR_P1_SETUP = 4'h7;
  localparam logic [3:0] ADDR_P2_SETUP = 4'h8;
  localparam logic [3:0] ADDR_P1_COUNT_LO = 4'h9;
  localparam logic [3:0] ADDR_P1_COUNT_HI = 4'ha;
  localparam logic [3:0] ADDR_P2_COUNT_LO = 4'hb;
  localparam logic [3:0] ADDR_P2_COUNT_HI = 4'hc;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'hd;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'he;
  localparam logic [3:0] ADDR_CTRL = 4'hf;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_CMP_RUN = 8;
  localparam int BIT_COMP_P1 = 1;
  localparam int BIT_COMP_P2 = 2;
  localparam int BIT_BOARD_ERR = 15;
  localparam int BIT_CTRL_PROG = 0;
  localparam int BIT_CTRL_RUN1 = 1;
  localparam int BIT_CTRL_RUN2 = 2;

  // ----------------------------------------
  // Encodings and reset values
  // ----------------------------------------
  localparam logic [7:0] RES_8 = 8'h00;
  localparam logic [7:0] RES_10 = 8'h01;
  localparam logic [7:0] RES_12 = 8'h02;
  localparam logic [7:0] MODE_BCD = 8'h00;
  localparam logic [7:0] MODE_DEG = 8'h01;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_SETUP = 8'h03;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0001;
  // Controller scan cycle: 1 ms at 10 MHz
  localparam int CLK_HZ = 10000000;
  localparam int SCAN_US = 1000;
  localparam int SCAN_CYC = SCAN_US * (CLK_HZ / 1000000);

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } aecs_count_s;

  typedef struct packed {
    logic [7:0] lower;
    logic [7:0] upper;
  } aecs_limit_s;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] res;
  } aecs_setup_s;
endpackage

// ---- aecs_enc_model.sv ----
// Behavioural absolute encoder that turns a shaft position into gray code
module aecs_enc_model (
  // Shaft position set by the bench
  input wire logic [11:0] pos_i,
  // Gray code towards the counter
  output logic [11:0] gray_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Continuous like a real disc; adjacent positions differ in one bit only
  assign gray_o = pos_i ^ (pos_i >> 1);
endmodule

// ---- test_abs_encoder_counter_status_config.sv ----
// Self-checking bench of the encoder counter status block
module test_abs_encoder_counter_status_config;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SCAN = 8;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic [11:0] pos1 = 12'h000;
  logic [11:0] pos2 = 12'h000;
  logic [11:0] enc1_gray_i;
  logic [11:0] enc2_gray_i;
  aecs_pkg::aecs_limit_s [7:0] range1_i;
  aecs_pkg::aecs_limit_s [7:0] range2_i;
  logic [7:0] hw_fault_i = 8'h00;
  logic irq_o;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  aecs_enc_model u_enc1 (.pos_i(pos1), .gray_o(enc1_gray_i));
  aecs_enc_model u_enc2 (.pos_i(pos2), .gray_o(enc2_gray_i));

  aecs_top #(.SCAN_CYCLES(SCAN)) u_dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .enc1_gray_i(enc1_gray_i), .enc2_gray_i(enc2_gray_i),
    .range1_i(range1_i), .range2_i(range2_i), .hw_fault_i(hw_fault_i), .irq_o(irq_o)
  );

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp, input string nm);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata_o & m);
  endtask

  function automatic logic [7:0] exp_m(input int p);
    for (int k = 0; k < 8; k++)
      exp_m[k] = (p >= 10 * k) && (p <= 10 * k + 15);
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(aecs_pkg::ADDR_P1_MATCH, 16'hffff, 16'h0000, "p1 status");
    rd(aecs_pkg::ADDR_P2_MATCH, 16'hffff, 16'h0000, "p2 status");
    rd(aecs_pkg::ADDR_ERR_CODE, 16'hff00, 16'h0000, "error code");
    rd(aecs_pkg::ADDR_SYS_ERR, 16'h8000, 16'h0000, "board error");
    rd(aecs_pkg::ADDR_COMP_REQ, 16'h0006, 16'h0000, "comp request");
  endtask

  task automatic t_comp;
    pos1 <= 12'd147;
    wr(aecs_pkg::ADDR_P1_SETUP, {aecs_pkg::MODE_BCD, aecs_pkg::RES_12});
    cyc(4);
    wr(aecs_pkg::ADDR_COMP_REQ, 16'h0002);
    rd(aecs_pkg::ADDR_P1_OFFSET, 16'hffff, 16'h0147, "p1 offset");
    rd(aecs_pkg::ADDR_COMP_REQ, 16'h0002, 16'h0000, "p1 request");
    cyc(2 * SCAN);
    rd(aecs_pkg::ADDR_P1_COUNT_LO, 16'hffff, 16'h0000, "p1 count lo");
    rd(aecs_pkg::ADDR_P1_COUNT_HI, 16'hffff, 16'h0000, "p1 count hi");
  endtask

  task automatic t_noprog;
    wr(aecs_pkg::ADDR_CTRL, 16'h0000);
    wr(aecs_pkg::ADDR_COMP_REQ, 16'h0004);
    cyc(4);
    rd(aecs_pkg::ADDR_COMP_REQ, 16'hffff, 16'h0004, "p2 request");
    rd(aecs_pkg::ADDR_P2_OFFSET, 16'hffff, 16'h0000, "p2 offset");
    wr(aecs_pkg::ADDR_COMP_REQ, 16'h0000);
  endtask

  task automatic t_count;
    pos1 <= 12'd167;
    pos2 <= 12'd40;
    cyc(2 * SCAN + 2);
    rd(aecs_pkg::ADDR_P1_COUNT_LO, 16'hffff, 16'h0020, "p1 count lo");
    rd(aecs_pkg::ADDR_P2_COUNT_LO, 16'hffff, 16'h0040, "p2 count lo");
  endtask

  task automatic t_cmp;
    wr(aecs_pkg::ADDR_P1_MATCH, 16'hffff);
    rd(aecs_pkg::ADDR_P1_MATCH, 16'hffff, 16'h0000, "p1 status ro");
    wr(aecs_pkg::ADDR_CTRL, 16'h0006);
    cyc(4);
    rd(aecs_pkg::ADDR_P1_MATCH, 16'hffff, {8'h01, exp_m(20)}, "p1 status");
    rd(aecs_pkg::ADDR_P2_MATCH, 16'hffff, {8'h01, exp_m(40)}, "p2 status");
    pos1 <= 12'd182;
    cyc(4);
    rd(aecs_pkg::ADDR_P1_MATCH, 16'hffff, {8'h01, exp_m(35)}, "p1 edge");
  endtask

  task automatic t_irq;
    wr(aecs_pkg::ADDR_IRQ_MASK, 16'h0004);
    cyc(2);
    #1;
    chk("irq on", 16'h0001, {15'h0, irq_o});
    wr(aecs_pkg::ADDR_IRQ_MASK, 16'h0000);
    cyc(2);
    #1;
    chk("irq masked", 16'h0000, {15'h0, irq_o});
    wr(aecs_pkg::ADDR_CTRL, 16'h0000);
    cyc(2);
    rd(aecs_pkg::ADDR_P1_MATCH, 16'h0100, 16'h0000, "p1 stopped");
    wr(aecs_pkg::ADDR_IRQ_STATUS, 16'hffff);
    rd(aecs_pkg::ADDR_IRQ_STATUS, 16'h000c, 16'h0000, "irq cleared");
    wr(aecs_pkg::ADDR_IRQ_MASK, 16'h000c);
    cyc(2);
    #1;
    chk("irq off", 16'h0000, {15'h0, irq_o});
  endtask

  // Reset while comparing, then port 2 compensation from program mode
  task automatic t_rerst;
    wr(aecs_pkg::ADDR_CTRL, 16'h0006);
    cyc(3);
    rd(aecs_pkg::ADDR_P2_MATCH, 16'h0100, 16'h0100, "p2 comparing");
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    cyc(3);
    nrst_i <= 1'b1;
    rd(aecs_pkg::ADDR_P1_MATCH, 16'hffff, 16'h0000, "p1 after reset");
    rd(aecs_pkg::ADDR_P2_MATCH, 16'hffff, 16'h0000, "p2 after reset");
    rd(aecs_pkg::ADDR_CTRL, 16'hffff, aecs_pkg::CTRL_RST, "ctrl after reset");
    wr(aecs_pkg::ADDR_COMP_REQ, 16'h0004);
    rd(aecs_pkg::ADDR_P2_OFFSET, 16'hffff, 16'h0040, "p2 offset");
    rd(aecs_pkg::ADDR_P2_COUNT_LO, 16'hffff, 16'h0000, "p2 count lo");
    rd(aecs_pkg::ADDR_COMP_REQ, 16'h0004, 16'h0000, "p2 request");
  endtask

  // Setup errors latch when program mode ends, so each word is tried in its own pass
  task automatic setup_err(input logic [15:0] s, input logic [15:0] code);
    wr(aecs_pkg::ADDR_CTRL, aecs_pkg::CTRL_RST);
    wr(aecs_pkg::ADDR_P1_SETUP, s);
    wr(aecs_pkg::ADDR_CTRL, 16'h0000);
    cyc(3);
    rd(aecs_pkg::ADDR_ERR_CODE, 16'hff00, code, "setup code");
    rd(aecs_pkg::ADDR_SYS_ERR, 16'h8000, (code != 16'h0000) ? 16'h8000 : 16'h0000, "board error");
  endtask

  task automatic t_err;
    hw_fault_i <= 8'h02;
    cyc(3);
    rd(aecs_pkg::ADDR_ERR_CODE, 16'hff00, 16'h0200, "hw code");
    rd(aecs_pkg::ADDR_SYS_ERR, 16'h8000, 16'h8000, "board error");
    rd(aecs_pkg::ADDR_IRQ_STATUS, 16'h0002, 16'h0002, "irq error");
    hw_fault_i <= 8'h01;
    cyc(3);
    rd(aecs_pkg::ADDR_ERR_CODE, 16'hff00, 16'h0100, "hw code");
    hw_fault_i <= 8'h00;
    setup_err(16'h0003, 16'h0300);
    setup_err(16'h0202, 16'h0300);
    setup_err({aecs_pkg::MODE_DEG, aecs_pkg::RES_10}, 16'h0000);
  endtask

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  initial
  begin
    for (int k = 0; k < 8; k++)
    begin
      range1_i[k].lower = 8'(10 * k);
      range1_i[k].upper = 8'(10 * k + 15);
    end
    range2_i = range1_i;
    cyc(6);
    nrst_i <= 1'b1;
    t_reset();
    t_comp();
    t_noprog();
    t_count();
    t_cmp();
    t_irq();
    t_err();
    t_rerst();
    wrap_up();
  end
endmodule
